//--- inc/lmsc_map.vh
// Constants for the load mode and setpoint controller.
// Assumes a 20 MHz mclk; setpoints are unsigned integers in milli-units.
`ifndef LMSC_MAP_VH
`define LMSC_MAP_VH

// ----------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------
`define LMSC_CLK_HZ        20000000
`define LMSC_MS_NS         1000000
`define LMSC_CLK_NS        50
`define LMSC_MS_CYCLES     (`LMSC_MS_NS / `LMSC_CLK_NS)
`define LMSC_DLY_MIN_MS    16'h0001
`define LMSC_DLY_MAX_MS    16'hea60

// ----------------------------------------------------------------
// Mode codes
// ----------------------------------------------------------------
`define LMSC_MODE_W        4
`define LMSC_M_CUR_LO      4'h0
`define LMSC_M_CUR_HI      4'h1
`define LMSC_M_VOL_LO      4'h2
`define LMSC_M_VOL_HI      4'h3
`define LMSC_M_RES_LO      4'h4
`define LMSC_M_RES_HI      4'h5
`define LMSC_M_POW         4'h6
`define LMSC_M_CUR_LO_CV   4'h7
`define LMSC_M_CUR_HI_CV   4'h8
`define LMSC_M_RES_LO_CV   4'h9
`define LMSC_M_RES_HI_CV   4'ha
`define LMSC_M_POW_CV      4'hb
`define LMSC_M_LAST        4'hb

// ----------------------------------------------------------------
// Quantities and setpoint limits (milli-units, 32 bits)
// ----------------------------------------------------------------
`define LMSC_Q_CUR         2'h0
`define LMSC_Q_VOL         2'h1
`define LMSC_Q_RES         2'h2
`define LMSC_Q_POW         2'h3
`define LMSC_SP_W          32
`define LMSC_CUR_LO_MAX    32'h0000_1770
`define LMSC_CUR_HI_MAX    32'h0002_49f0
`define LMSC_VOL_LO_MAX    32'h0000_5dc0
`define LMSC_VOL_HI_MAX    32'h0003_a980
`define LMSC_RES_LO_MIN    32'h0000_000a
`define LMSC_RES_LO_MAX    32'h0e4e_1c00
`define LMSC_RES_HI_MIN    32'h0000_00c8
`define LMSC_RES_HI_MAX    32'h8f0d_1800
`define LMSC_POW_MAX       32'h001e_8480
`define LMSC_ZERO          32'h0000_0000
`define LMSC_RES_RESET     32'h0000_03e8

`endif

//--- src/lmsc_ctrl.v
// Mode selection, local/remote arbitration, setpoint handling and
// software over-current protection for an electronic load.
// Assumes host commands arrive decoded as one-cycle strobes on mclk and
// front-panel keys arrive as raw levels from pins.
`timescale 1ns/1ps
`include "lmsc_map.vh"

module lmsc_ctrl (
  input  wire        mclk,
  input  wire        rst_n,
  input  wire        host_remote,
  input  wire        host_local,
  input  wire        host_mode_wr,
  input  wire [3:0]  host_mode,
  input  wire        host_input_on,
  input  wire        host_input_off,
  input  wire        host_level_wr,
  input  wire        host_preset_wr,
  input  wire        host_alt_wr,
  input  wire [1:0]  host_qty,
  input  wire [31:0] host_value,
  input  wire        host_trigger,
  input  wire        host_tran_on,
  input  wire        host_tran_off,
  input  wire        host_prot_wr,
  input  wire        host_dly_wr,
  input  wire [15:0] host_dly_ms,
  input  wire        key_local,
  input  wire        key_mode,
  input  wire [3:0]  key_mode_sel,
  input  wire        key_onoff,
  input  wire        key_level,
  input  wire [31:0] key_value,
  input  wire        key_tran,
  input  wire        tran_phase,
  input  wire [31:0] meas_current,
  output wire        remote_ind,
  output reg  [3:0]  mode_reg,
  output reg         input_on_reg,
  output reg  [31:0] applied_level_reg,
  output reg         alarm_reg,
  output reg  [3:0]  pending_reg,
  output reg         tran_reg,
  output reg         ocp_trip_reg
);

  // ----------------------------------------------------------------
  // Control states
  // ----------------------------------------------------------------
  localparam [1:0] ST_LOCAL  = 2'b01;
  localparam [1:0] ST_REMOTE = 2'b10;

  reg  [1:0]  state_reg;
  reg  [1:0]  state_next;
  reg  [31:0] imm_reg   [0:3];
  reg  [31:0] trig_reg  [0:3];
  reg  [31:0] alt_reg   [0:3];
  reg  [31:0] prot_reg;
  reg  [15:0] dly_reg;
  reg  [15:0] ms_cnt_reg;
  reg  [15:0] ocp_ms_reg;
  reg  [31:0] clamp_val;
  reg  [1:0]  act_qty;
  reg  [31:0] lo_lim;
  reg  [31:0] hi_lim;
  wire        ocp_fire;

  // ----------------------------------------------------------------
  // Pin input synchronisers
  // ----------------------------------------------------------------
  reg  [4:0]  key_s1_reg;
  reg  [4:0]  key_s2_reg;
  reg  [4:0]  key_d_reg;
  reg  [3:0]  ksel_s1_reg;
  reg  [3:0]  ksel_s2_reg;
  reg  [31:0] kval_s1_reg;
  reg  [31:0] kval_s2_reg;
  reg  [31:0] meas_s1_reg;
  reg  [31:0] meas_s2_reg;
  reg         phase_s1_reg;
  reg         phase_s2_reg;

  // Two flops on every pin input, then edge detect on the second stage of the five keys
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      key_s1_reg   <= 5'h00;
      key_s2_reg   <= 5'h00;
      key_d_reg    <= 5'h00;
      ksel_s1_reg  <= 4'h0;
      ksel_s2_reg  <= 4'h0;
      kval_s1_reg  <= 32'h0000_0000;
      kval_s2_reg  <= 32'h0000_0000;
      meas_s1_reg  <= 32'h0000_0000;
      meas_s2_reg  <= 32'h0000_0000;
      phase_s1_reg <= 1'b0;
      phase_s2_reg <= 1'b0;
    end else begin
      key_s1_reg   <= {key_tran, key_level, key_onoff, key_mode, key_local};
      key_s2_reg   <= key_s1_reg;
      key_d_reg    <= key_s2_reg;
      ksel_s1_reg  <= key_mode_sel;
      ksel_s2_reg  <= ksel_s1_reg;
      kval_s1_reg  <= key_value;
      kval_s2_reg  <= kval_s1_reg;
      meas_s1_reg  <= meas_current;
      meas_s2_reg  <= meas_s1_reg;
      phase_s1_reg <= tran_phase;
      phase_s2_reg <= phase_s1_reg;
    end
  end

  wire [4:0] key_rise = key_s2_reg & ~key_d_reg;
  wire       is_local = state_reg[0];

  // Panel actions count only in local control; local key always counts
  wire p_local = key_rise[0];
  wire p_mode  = key_rise[1] & is_local;
  wire p_onoff = key_rise[2] & is_local;
  wire p_level = key_rise[3] & is_local;
  wire p_tran  = key_rise[4] & is_local;

  // ----------------------------------------------------------------
  // Local / remote arbitration
  // ----------------------------------------------------------------
  // A host local command wins over an enter-remote in the same cycle; the local key does not
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_LOCAL: begin
        if (host_remote && !host_local) state_next = ST_REMOTE;
      end
      ST_REMOTE: begin
        if (host_local || p_local) state_next = ST_LOCAL;
      end
      default: state_next = ST_LOCAL;
    endcase
  end

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) state_reg <= ST_LOCAL;
    else state_reg <= state_next;
  end

  assign remote_ind = state_reg[1];

  // ----------------------------------------------------------------
  // Mode decode and setpoint limits
  // ----------------------------------------------------------------
  wire       mode_req = host_mode_wr | p_mode;
  wire [3:0] mode_new = host_mode_wr ? host_mode : ksel_s2_reg;
  wire       mode_ok  = mode_new <= `LMSC_M_LAST;
  wire       mode_chg = mode_req & mode_ok & (mode_new != mode_reg);

  // Quantity regulated by a given mode
  function [1:0] lmsc_qty;
    input [3:0] m;
    begin
      case (m)
        `LMSC_M_VOL_LO, `LMSC_M_VOL_HI:                     lmsc_qty = `LMSC_Q_VOL;
        `LMSC_M_RES_LO, `LMSC_M_RES_HI,
        `LMSC_M_RES_LO_CV, `LMSC_M_RES_HI_CV:               lmsc_qty = `LMSC_Q_RES;
        `LMSC_M_POW, `LMSC_M_POW_CV:                        lmsc_qty = `LMSC_Q_POW;
        default:                                            lmsc_qty = `LMSC_Q_CUR;
      endcase
    end
  endfunction

  // Limits of a quantity in the range that a mode implies
  task lmsc_limits;
    input  [3:0]  m;
    input  [1:0]  q;
    output [31:0] lo;
    output [31:0] hi;
    reg           hi_rng;
    begin
      hi_rng = (m == `LMSC_M_CUR_HI) || (m == `LMSC_M_CUR_HI_CV) ||
               (m == `LMSC_M_VOL_HI) || (m == `LMSC_M_RES_HI) ||
               (m == `LMSC_M_RES_HI_CV);
      lo = `LMSC_ZERO;
      hi = `LMSC_POW_MAX;
      case (q)
        `LMSC_Q_CUR: hi = hi_rng ? `LMSC_CUR_HI_MAX : `LMSC_CUR_LO_MAX;
        `LMSC_Q_VOL: hi = hi_rng ? `LMSC_VOL_HI_MAX : `LMSC_VOL_LO_MAX;
        `LMSC_Q_RES: begin
          lo = hi_rng ? `LMSC_RES_HI_MIN : `LMSC_RES_LO_MIN;
          hi = hi_rng ? `LMSC_RES_HI_MAX : `LMSC_RES_LO_MAX;
        end
        default: hi = `LMSC_POW_MAX;
      endcase
    end
  endtask

  // Saturate a value into the limits for the written quantity
  wire [1:0]  wr_qty = (host_level_wr | host_preset_wr | host_alt_wr) ? host_qty
                       : lmsc_qty(mode_reg);
  wire [31:0] wr_raw = p_level ? kval_s2_reg : host_value;
  always @* begin
    act_qty = lmsc_qty(mode_reg);
    lmsc_limits(mode_reg, wr_qty, lo_lim, hi_lim);
    if (wr_raw > hi_lim) clamp_val = hi_lim;
    else if (wr_raw < lo_lim) clamp_val = lo_lim;
    else clamp_val = wr_raw;
  end

  // Limits of the quantity that a pending mode change lands in
  reg [31:0] nlo;
  reg [31:0] nhi;
  wire [1:0] new_qty = lmsc_qty(mode_new);
  always @* begin
    lmsc_limits(mode_new, new_qty, nlo, nhi);
  end

  // ----------------------------------------------------------------
  // Mode, input and transient state
  // ----------------------------------------------------------------
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mode_reg     <= `LMSC_M_CUR_LO;
      input_on_reg <= 1'b0;
      tran_reg     <= 1'b0;
    end else begin
      if (mode_chg) mode_reg <= mode_new;
      if (mode_chg || ocp_fire) input_on_reg <= 1'b0;
      else if (host_input_off) input_on_reg <= 1'b0;
      else if (host_input_on || (p_onoff && !input_on_reg)) input_on_reg <= 1'b1;
      else if (p_onoff) input_on_reg <= 1'b0;
      if (host_tran_off) tran_reg <= 1'b0;
      else if (host_tran_on || (p_tran && !tran_reg)) tran_reg <= 1'b1;
      else if (p_tran) tran_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Immediate, triggered and alternate levels per quantity
  // ----------------------------------------------------------------
  genvar gq;
  generate
    for (gq = 0; gq < 4; gq = gq + 1) begin : g_qty
      localparam [31:0] QI = gq;
      wire [1:0] qn = QI[1:0];
      always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          imm_reg[gq]     <= (gq == 2) ? `LMSC_RES_RESET : `LMSC_ZERO;
          trig_reg[gq]    <= (gq == 2) ? `LMSC_RES_RESET : `LMSC_ZERO;
          alt_reg[gq]     <= (gq == 2) ? `LMSC_RES_RESET : `LMSC_ZERO;
          pending_reg[gq] <= 1'b0;
        end else begin
          if (host_trigger && pending_reg[gq])
            imm_reg[gq] <= trig_reg[gq];
          else if ((host_level_wr && host_qty == qn) || (p_level && act_qty == qn))
            imm_reg[gq] <= clamp_val;
          else if (mode_chg && new_qty == qn && imm_reg[gq] > nhi)
            imm_reg[gq] <= nhi;
          else if (mode_chg && new_qty == qn && imm_reg[gq] < nlo)
            imm_reg[gq] <= nlo;
          // Only the host reaches the preset; a new write wins over trigger
          if (host_preset_wr && host_qty == qn) begin
            trig_reg[gq]    <= clamp_val;
            pending_reg[gq] <= 1'b1;
          end else if (host_trigger) begin
            pending_reg[gq] <= 1'b0;
          end
          if (host_alt_wr && host_qty == qn) alt_reg[gq] <= clamp_val;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Applied level
  // ----------------------------------------------------------------
  // Follows the active quantity only; other quantities wait for their mode
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) applied_level_reg <= `LMSC_ZERO;
    else if (!input_on_reg) applied_level_reg <= `LMSC_ZERO;
    else if (tran_reg && phase_s2_reg) applied_level_reg <= alt_reg[act_qty];
    else applied_level_reg <= imm_reg[act_qty];
  end

  // ----------------------------------------------------------------
  // Software over-current protection
  // ----------------------------------------------------------------
  wire [15:0] dly_in = (host_dly_ms < `LMSC_DLY_MIN_MS) ? `LMSC_DLY_MIN_MS :
                       (host_dly_ms > `LMSC_DLY_MAX_MS) ? `LMSC_DLY_MAX_MS : host_dly_ms;
  wire        over    = meas_s2_reg > prot_reg;
  wire        ms_tick = ms_cnt_reg == (`LMSC_MS_CYCLES - 1);
  assign ocp_fire = over && ms_tick && (ocp_ms_reg + 16'h0001 >= dly_reg);

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      prot_reg     <= `LMSC_CUR_HI_MAX;
      dly_reg      <= `LMSC_DLY_MIN_MS;
      ms_cnt_reg   <= 16'h0000;
      ocp_ms_reg   <= 16'h0000;
      ocp_trip_reg <= 1'b0;
      alarm_reg    <= 1'b0;
    end else begin
      if (host_prot_wr)
        prot_reg <= (host_value > `LMSC_CUR_HI_MAX) ? `LMSC_CUR_HI_MAX : host_value;
      if (host_dly_wr) dly_reg <= dly_in;
      if (!over) begin
        ms_cnt_reg <= 16'h0000;
        ocp_ms_reg <= 16'h0000;
      end else if (ms_tick) begin
        ms_cnt_reg <= 16'h0000;
        if (!ocp_fire) ocp_ms_reg <= ocp_ms_reg + 16'h0001;
      end else begin
        ms_cnt_reg <= ms_cnt_reg + 16'h0001;
      end
      // Trip and alarm stay until the input is switched on again
      if (ocp_fire) begin
        ocp_trip_reg <= 1'b1;
        alarm_reg    <= 1'b1;
      end else if (host_input_on || p_onoff) begin
        ocp_trip_reg <= 1'b0;
        alarm_reg    <= 1'b0;
      end
    end
  end

endmodule

//--- testbench/lmsc_ctrl_properties.sv
// Concurrent checks on the ports of the load mode and setpoint controller.
// Assumes one clock domain, mclk, with asynchronous active-low reset rst_n.
`timescale 1ns/1ps
`include "lmsc_map.vh"
module lmsc_ctrl_properties (
  input wire        mclk,
  input wire        rst_n,
  input wire        host_remote,
  input wire        host_local,
  input wire        host_mode_wr,
  input wire [3:0]  host_mode,
  input wire        host_preset_wr,
  input wire [1:0]  host_qty,
  input wire        remote_ind,
  input wire [3:0]  mode_reg,
  input wire        input_on_reg,
  input wire [31:0] applied_level_reg,
  input wire        alarm_reg,
  input wire [3:0]  pending_reg,
  input wire        ocp_trip_reg
);
  // ----------------------------------------------------------------
  // Port relations
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  property p_remote_on;
    host_remote && !host_local |=> remote_ind;
  endproperty
  a_remote_on: assert property (p_remote_on) else $error("remote not entered");
  property p_host_local;
    host_local |=> !remote_ind;
  endproperty
  a_host_local: assert property (p_host_local) else $error("local not restored");
  property p_mode_off;
    host_mode_wr && host_mode <= `LMSC_M_LAST && host_mode != mode_reg
      |=> mode_reg == $past(host_mode) && !input_on_reg;
  endproperty
  a_mode_off: assert property (p_mode_off) else $error("mode change left input on");
  property p_mode_hold;
    remote_ind && !host_mode_wr |=> $stable(mode_reg);
  endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("mode moved without host");
  property p_cur_range;
    (mode_reg == `LMSC_M_CUR_LO) [*2] |-> applied_level_reg <= `LMSC_CUR_LO_MAX;
  endproperty
  a_cur_range: assert property (p_cur_range) else $error("low current level too high");
  property p_preset_pend;
    host_preset_wr |=> pending_reg[$past(host_qty)];
  endproperty
  a_preset_pend: assert property (p_preset_pend) else $error("pending not set");
  property p_pend_src;
    (|(pending_reg & ~$past(pending_reg))) |-> $past(host_preset_wr);
  endproperty
  a_pend_src: assert property (p_pend_src) else $error("pending set without host");
  property p_trip;
    $rose(ocp_trip_reg) |-> alarm_reg && !input_on_reg;
  endproperty
  a_trip: assert property (p_trip) else $error("trip without alarm or off");
endmodule

//--- testbench/lmsc_host_model.sv
// Behavioural remote host that issues decoded one-cycle command strobes.
// Assumes the controller samples strobes on the rising edge of mclk.
`timescale 1ns/1ps
module lmsc_host_model (
  input  wire        mclk,
  output reg  [12:0] stb,
  output reg  [3:0]  mode,
  output reg  [1:0]  qty,
  output reg  [31:0] value
);
  // ----------------------------------------------------------------
  // Command issue
  // ----------------------------------------------------------------
  initial begin
    stb = 13'h0000;
    mode = 4'h0;
    qty = 2'h0;
    value = 32'h0000_0000;
  end
  // Remote, preset and threshold commands come only from here
  task send(input integer s, input [3:0] m, input [1:0] q, input [31:0] v);
    begin
      @(negedge mclk);
      mode = m;
      qty = q;
      value = v;
      stb[s] = 1'b1;
      @(negedge mclk);
      stb = 13'h0000;
      value = ~v;  // Released data does not keep its value
    end
  endtask
endmodule

//--- testbench/testbench.sv
// Self-checking bench for the load mode and setpoint controller.
// Assumes the host model and the port checker are compiled beforehand.
`timescale 1ns/1ps
`include "lmsc_map.vh"
`define CHK(nm, e, g) begin tests_run = tests_run + 1; if ((g) !== (e)) begin \
  bad_count = bad_count + 1; $display("mismatch %s exp %0h got %0h", nm, e, g); end end
module testbench;
  localparam S_REM = 0, S_LOC = 1, S_MODE = 2, S_ON = 3, S_OFF = 4, S_LVL = 5, S_PRE = 6;
  localparam S_ALT = 7, S_TRIG = 8, S_TON = 9, S_TOFF = 10, S_PROT = 11, S_DLY = 12;
  reg         mclk;
  reg         rst_n;
  reg  [4:0]  keys;
  reg  [3:0]  key_sel;
  reg  [31:0] key_val;
  reg         tran_phase;
  reg  [31:0] meas;
  wire [12:0] stb;
  wire [3:0]  h_mode;
  wire [1:0]  h_qty;
  wire [31:0] h_val;
  wire        remote_ind;
  wire [3:0]  mode_reg;
  wire        input_on_reg;
  wire [31:0] applied_level_reg;
  wire        alarm_reg;
  wire [3:0]  pending_reg;
  wire        tran_reg;
  wire        ocp_trip_reg;
  integer     bad_count;
  integer     tests_run;
  integer     i;
  // ----------------------------------------------------------------
  // Clock, host and design
  // ----------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  lmsc_host_model u_host (.mclk(mclk), .stb(stb), .mode(h_mode), .qty(h_qty), .value(h_val));
  lmsc_ctrl i_lmsc_ctrl (.mclk(mclk), .rst_n(rst_n), .host_remote(stb[S_REM]),
    .host_local(stb[S_LOC]), .host_mode_wr(stb[S_MODE]), .host_mode(h_mode),
    .host_input_on(stb[S_ON]), .host_input_off(stb[S_OFF]), .host_level_wr(stb[S_LVL]),
    .host_preset_wr(stb[S_PRE]), .host_alt_wr(stb[S_ALT]), .host_qty(h_qty),
    .host_value(h_val), .host_trigger(stb[S_TRIG]), .host_tran_on(stb[S_TON]),
    .host_tran_off(stb[S_TOFF]), .host_prot_wr(stb[S_PROT]), .host_dly_wr(stb[S_DLY]),
    .host_dly_ms(h_val[15:0]), .key_local(keys[0]), .key_mode(keys[1]), .key_onoff(keys[2]),
    .key_level(keys[3]), .key_tran(keys[4]), .key_mode_sel(key_sel), .key_value(key_val),
    .tran_phase(tran_phase), .meas_current(meas), .remote_ind(remote_ind),
    .mode_reg(mode_reg), .input_on_reg(input_on_reg), .applied_level_reg(applied_level_reg),
    .alarm_reg(alarm_reg), .pending_reg(pending_reg), .tran_reg(tran_reg),
    .ocp_trip_reg(ocp_trip_reg));
  task wt(input integer n);
    repeat (n) @(negedge mclk);
  endtask
  // Panel key: hold past the synchroniser, then release
  task press(input integer k);
    begin
      keys[k] = 1'b1;
      wt(5);
      keys[k] = 1'b0;
      wt(5);
    end
  endtask
  task give_verdict;
    begin
      $display("comparisons %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
        $display("Test passed");
      end else begin
        $display("Test failed");
      end
      $finish;
    end
  endtask
  // Main sequence
  initial begin
    bad_count = 0;
    tests_run = 0;
    rst_n = 1'b0;
    keys = 5'h00;
    key_sel = `LMSC_M_CUR_HI;
    key_val = 32'd1234;
    tran_phase = 1'b0;
    meas = 32'h0000_0000;
    wt(11);
    rst_n = 1'b1;
    wt(2);
    `CHK("remote", 1'b0, remote_ind)
    press(1);
    `CHK("key mode", `LMSC_M_CUR_HI, mode_reg)
    press(3);
    `CHK("panel preset", 4'h0, pending_reg)
    u_host.send(S_REM, 0, 0, 0);
    wt(2);
    `CHK("remote on", 1'b1, remote_ind)
    key_sel = `LMSC_M_VOL_LO;
    press(1);
    `CHK("key ignored", `LMSC_M_CUR_HI, mode_reg)
    press(0);
    `CHK("key local", 1'b0, remote_ind)
    u_host.send(S_REM, 0, 0, 0);
    u_host.send(S_LOC, 0, 0, 0);
    wt(2);
    `CHK("host local", 1'b0, remote_ind)
    $display("test arbitration done");
    u_host.send(S_LVL, 0, `LMSC_Q_CUR, 32'd200000);
    u_host.send(S_ON, 0, 0, 0);
    wt(3);
    `CHK("cc hi", `LMSC_CUR_HI_MAX, applied_level_reg)
    u_host.send(S_MODE, `LMSC_M_CUR_LO, 0, 0);
    wt(2);
    `CHK("off on change", 1'b0, input_on_reg)
    u_host.send(S_ON, 0, 0, 0);
    wt(3);
    `CHK("cc lo", `LMSC_CUR_LO_MAX, applied_level_reg)
    u_host.send(S_MODE, 4'hc, 0, 0);
    wt(2);
    `CHK("bad code", `LMSC_M_CUR_LO, mode_reg)
    `CHK("still on", 1'b1, input_on_reg)
    for (i = 0; i < 12; i = i + 1) begin
      u_host.send(S_MODE, i[3:0], 0, 0);
      wt(2);
      `CHK("mode code", i[3:0], mode_reg)
    end
    u_host.send(S_MODE, `LMSC_M_VOL_HI, 0, 0);
    u_host.send(S_LVL, 0, `LMSC_Q_VOL, 32'd300000);
    u_host.send(S_ON, 0, 0, 0);
    wt(3);
    `CHK("cv hi", `LMSC_VOL_HI_MAX, applied_level_reg)
    u_host.send(S_MODE, `LMSC_M_VOL_LO, 0, 0);
    u_host.send(S_LVL, 0, `LMSC_Q_VOL, 32'd30000);
    u_host.send(S_ON, 0, 0, 0);
    wt(3);
    `CHK("cv lo", `LMSC_VOL_LO_MAX, applied_level_reg)
    $display("test setpoints done");
    u_host.send(S_PRE, 0, `LMSC_Q_VOL, 32'd5000);
    wt(1);
    `CHK("pending", 4'h2, pending_reg)
    u_host.send(S_TRIG, 0, 0, 0);
    wt(3);
    `CHK("pend clear", 4'h0, pending_reg)
    `CHK("trig apply", 32'd5000, applied_level_reg)
    u_host.send(S_PRE, 0, `LMSC_Q_CUR, 32'd3000);
    u_host.send(S_TRIG, 0, 0, 0);
    wt(3);
    `CHK("other qty", 32'd5000, applied_level_reg)
    u_host.send(S_LVL, 0, `LMSC_Q_VOL, 32'd7000);
    u_host.send(S_TRIG, 0, 0, 0);
    wt(3);
    `CHK("retrigger", 32'd7000, applied_level_reg)
    u_host.send(S_MODE, `LMSC_M_CUR_LO, 0, 0);
    u_host.send(S_ON, 0, 0, 0);
    wt(3);
    `CHK("later mode", 32'd3000, applied_level_reg)
    $display("test triggers done");
    u_host.send(S_ALT, 0, `LMSC_Q_CUR, 32'd1000);
    u_host.send(S_TON, 0, 0, 0);
    tran_phase = 1'b1;
    wt(5);
    `CHK("tran on", 1'b1, tran_reg)
    `CHK("tran hi", 32'd1000, applied_level_reg)
    tran_phase = 1'b0;
    wt(5);
    `CHK("tran lo", 32'd3000, applied_level_reg)
    u_host.send(S_TOFF, 0, 0, 0);
    $display("test transient done");
    u_host.send(S_MODE, `LMSC_M_VOL_HI, 0, 0);
    u_host.send(S_ON, 0, 0, 0);
    u_host.send(S_PROT, 0, 0, 32'd200000);
    u_host.send(S_DLY, 0, 0, 32'd1);
    meas = 32'd150001;
    wt(15000);
    meas = `LMSC_CUR_HI_MAX;
    wt(15000);
    `CHK("at limit", 1'b1, input_on_reg)
    meas = 32'd150001;
    wt(15000);
    `CHK("restart", 1'b0, ocp_trip_reg)
    wt(4900);
    `CHK("early", 1'b0, ocp_trip_reg)
    for (i = 0; i < 300 && ocp_trip_reg !== 1'b1; i = i + 1) wt(1);
    `CHK("trip", 1'b1, ocp_trip_reg)
    `CHK("trip off", 1'b0, input_on_reg)
    `CHK("alarm", 1'b1, alarm_reg)
    meas = 32'h0000_0000;
    press(2);
    `CHK("key on", 1'b1, input_on_reg)
    `CHK("trip clear", 1'b0, ocp_trip_reg)
    `CHK("alarm clear", 1'b0, alarm_reg)
    u_host.send(S_OFF, 0, 0, 0);
    wt(2);
    `CHK("host off", 1'b0, input_on_reg)
    press(4);
    `CHK("key tran", 1'b1, tran_reg)
    $display("test protection done");
    give_verdict;
  end
endmodule
bind lmsc_ctrl lmsc_ctrl_properties i_props (.mclk(mclk), .rst_n(rst_n),
  .host_remote(host_remote), .host_local(host_local), .host_mode_wr(host_mode_wr),
  .host_mode(host_mode), .host_preset_wr(host_preset_wr), .host_qty(host_qty),
  .remote_ind(remote_ind), .mode_reg(mode_reg), .input_on_reg(input_on_reg),
  .applied_level_reg(applied_level_reg), .alarm_reg(alarm_reg), .pending_reg(pending_reg),
  .ocp_trip_reg(ocp_trip_reg));
